// ===== wwt_pkg.sv
// ============================================================
// windowed watchdog constants
package wwt_pkg;
    // refresh key and apb byte offsets
    localparam logic [7:0]  REFRESH_KEY  = 8'hAC;
    localparam logic [7:0]  OFS_REFRESH  = 8'h00;  // key byte write
    localparam logic [7:0]  OFS_BITOP    = 8'h04;  // single-bit op alias
    localparam logic [7:0]  OFS_CONFIG   = 8'h08;
    localparam logic [7:0]  OFS_STATUS   = 8'h0C;  // read clears
    localparam logic [7:0]  OFS_MASK     = 8'h10;
    localparam logic [7:0]  OFS_COUNT    = 8'h14;  // read only
    localparam logic [7:0]  OFS_MEMSEL   = 8'h18;
    // config fields
    localparam int          CFG_STBY     = 0;      // standby_run_bit
    localparam int          CFG_OVF_LSB  = 1;      // overflow select [3:1]
    localparam int          CFG_RUN      = 4;      // counter_run_bit
    localparam int          CFG_SPAN_LSB = 5;      // open span select [6:5]
    localparam logic [7:0]  CONFIG_RST   = 8'h00;
    localparam logic [13:0] MEMSEL_RST   = 14'h0000;
    localparam logic [1:0]  SPAN_50      = 2'h1;
    localparam logic [1:0]  SPAN_75      = 2'h2;
    // status and mask bits
    localparam int          ST_INTV      = 0;
    localparam int          ST_OVF       = 1;
    localparam int          ST_BITOP     = 2;
    localparam int          ST_KEY       = 3;
    localparam int          ST_CLOSED    = 4;
    localparam int          ST_FETCH     = 5;
    localparam int          ST_DATA      = 6;
    localparam int          ST_W         = 7;
    // counter and overflow exponents, index = overflow select
    localparam int          CNT_W        = 17;
    localparam logic [7:0][4:0] OVF_EXP  = {5'h10, 5'h0E, 5'h0D, 5'h0B,
                                            5'h09, 5'h08, 5'h07, 5'h06};
    // timing: shortest overflow is 2^6 slow periods
    localparam int          REF_CLK_NS    = 40;
    localparam int          LS_MIN_OVF_US = 3710;
    localparam int          LS_DIV_DEF    = (LS_MIN_OVF_US * 1000) / (64 * REF_CLK_NS);
    localparam logic [3:0]  RST_HOLD_CYC  = 4'h8;
    // memory map for area checks
    localparam logic [15:0] XRAM_TOP     = 16'hFB00;
    localparam logic [15:0] EXC0_LO      = 16'hFB00;
    localparam logic [15:0] EXC0_HI      = 16'hFFCF;
    localparam logic [15:0] EXC1_LO      = 16'hFFE0;
    // controller states
    typedef enum logic [1:0] {
        WWT_RUN  = 2'b01,
        WWT_HOLD = 2'b10
    } wwt_state_t;
endpackage : wwt_pkg

// ===== wwt_top.sv
`timescale 1ns/10ps
// How it works
// - key AC in open window restarts counter
// - counter overflow asserts internal reset
// - single-bit op on refresh asserts reset
// - non-key write to refresh asserts reset
// - refresh write in closed window resets
// - fetch outside configured areas resets
// - data access outside areas resets, exceptions
// - three bits pick overflow 2^6..2^16
// - open span 50/75/100%, 100% without standby
// - counter runs only when run bit set
// - interval warning at 75% plus half
module wwt_top #(
    parameter int LS_DIV    = wwt_pkg::LS_DIV_DEF,
    parameter bit MEM_CHECK = 1'b1
) (
    input  wire logic        REF_CLK,
    input  wire logic        RST_N,
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [7:0]  PADDR,
    input  wire logic [31:0] PWDATA,
    output logic      [31:0] PRDATA,
    output logic             PREADY,
    output logic             PSLVERR,
    input  wire logic        STANDBY,
    input  wire logic        FETCH_VALID,
    input  wire logic [15:0] FETCH_ADDR,
    input  wire logic        DATA_VALID,
    input  wire logic [15:0] DATA_ADDR,
    output logic             IRQ,
    output logic             WDT_RESET
);
    // ============================================================
    // elaboration checks
    // a shorter divider leaves no room between the half point and the tick
    if (LS_DIV < 4 || LS_DIV > 65535) begin : g_bad_div
        $error("LS_DIV out of range");
    end

    // ============================================================
    // state
    wwt_pkg::wwt_state_t       state_ff;       // run or reset hold
    wwt_pkg::wwt_state_t       nxt_state;
    logic [3:0]                hold_ff;        // reset hold countdown
    logic [3:0]                nxt_hold;
    logic [15:0]               pre_ff;         // slow clock divider
    logic [15:0]               nxt_pre;
    logic [wwt_pkg::CNT_W-1:0] cnt_ff;         // watchdog counter
    logic [wwt_pkg::CNT_W-1:0] nxt_cnt;
    logic [7:0]                cfg_ff;         // option settings
    logic [13:0]               memsel_ff;      // rom kb / xram 256b units
    logic [wwt_pkg::ST_W-1:0]  st_ff;          // sticky events
    logic [wwt_pkg::ST_W-1:0]  nxt_st;
    logic [wwt_pkg::ST_W-1:0]  mask_ff;
    logic                      pready_ff;
    logic                      pslverr_ff;
    logic [31:0]               prdata_ff;
    logic                      irq_ff;
    logic                      rst_out_ff;

    // ============================================================
    // apb decode
    // one wait state so read data can come from a flop
    wire        acc       = PSEL & PENABLE & pready_ff;
    wire        wr        = acc & PWRITE;
    wire        rd        = acc & ~PWRITE;
    wire        sel_ref   = PADDR == wwt_pkg::OFS_REFRESH;
    wire        sel_bit   = PADDR == wwt_pkg::OFS_BITOP;
    wire        sel_cfg   = PADDR == wwt_pkg::OFS_CONFIG;
    wire        sel_st    = PADDR == wwt_pkg::OFS_STATUS;
    wire        sel_mask  = PADDR == wwt_pkg::OFS_MASK;
    wire        sel_cnt   = PADDR == wwt_pkg::OFS_COUNT;
    wire        sel_mem   = PADDR == wwt_pkg::OFS_MEMSEL;
    wire        mapped    = sel_ref | sel_bit | sel_cfg | sel_st |
                            sel_mask | sel_cnt | sel_mem;
    wire        in_run    = state_ff == wwt_pkg::WWT_RUN;
    wire        cfg_wr    = wr & sel_cfg;

    // read mux; write-only registers read as zero
    wire [31:0] rd_mux    = sel_cfg  ? {24'h000000, cfg_ff} :
                            sel_st   ? {25'h0000000, st_ff} :
                            sel_mask ? {25'h0000000, mask_ff} :
                            sel_cnt  ? {15'h0000, cnt_ff} :
                            sel_mem  ? {18'h00000, memsel_ff} :
                                       32'h00000000;

    // ============================================================
    // overflow and window arithmetic
    wire [2:0]  ovf_sel   = cfg_ff[wwt_pkg::CFG_OVF_LSB +: 3];
    wire [4:0]  ovf_exp   = wwt_pkg::OVF_EXP[ovf_sel];
    wire [wwt_pkg::CNT_W-1:0] ovf_lim = 17'h00001 << ovf_exp;
    wire [wwt_pkg::CNT_W-1:0] ovf_max = ovf_lim - 17'h00001;
    wire [wwt_pkg::CNT_W-1:0] quarter = ovf_lim >> 2;
    wire [wwt_pkg::CNT_W-1:0] three_q = ovf_lim - quarter;
    wire        stby_run  = cfg_ff[wwt_pkg::CFG_STBY];
    wire [1:0]  span      = cfg_ff[wwt_pkg::CFG_SPAN_LSB +: 2];
    // closed part sits at the start of each period
    // without standby run the window is always fully open
    wire [wwt_pkg::CNT_W-1:0] closed_len =
        ~stby_run                   ? 17'h00000 :
        (span == wwt_pkg::SPAN_50)  ? (ovf_lim >> 1) :
        (span == wwt_pkg::SPAN_75)  ? quarter :
                                      17'h00000;
    wire        win_open  = cnt_ff >= closed_len;

    // ============================================================
    // slow clock tick and run gate
    // divider stands in for the slow oscillator; sharing one clock
    // avoids a crossing at the cost of a coarse period
    wire        running   = in_run & cfg_ff[wwt_pkg::CFG_RUN] &
                            ~(STANDBY & ~stby_run);
    wire        tick      = pre_ff == 16'(LS_DIV - 1);
    wire        half_pt   = pre_ff == 16'(LS_DIV / 2);

    // ============================================================
    // fault and event sources
    wire        ref_wr    = wr & sel_ref & in_run;
    wire        key_ok    = PWDATA[7:0] == wwt_pkg::REFRESH_KEY;
    wire        refresh   = ref_wr & key_ok & win_open;
    wire        ev_key    = ref_wr & ~key_ok;
    wire        ev_closed = ref_wr & ~win_open;
    wire        ev_bitop  = wr & sel_bit & in_run;
    wire        ev_ovf    = running & tick & (cnt_ff == ovf_max);
    wire        ev_intv   = running & half_pt & (cnt_ff == three_q);

    // area membership: rom from zero, xram just below its top
    function automatic logic in_area(input logic [15:0] a,
                                     input logic [13:0] m);
        logic [15:0] rom_lim;
        logic [15:0] xram_lo;
        rom_lim = {m[5:0], 10'h000};
        xram_lo = wwt_pkg::XRAM_TOP - {m[13:8], 8'h00};
        in_area = (a < rom_lim) | ((a >= xram_lo) & (a < wwt_pkg::XRAM_TOP));
    endfunction : in_area

    wire        data_exc  = ((DATA_ADDR >= wwt_pkg::EXC0_LO) &
                             (DATA_ADDR <= wwt_pkg::EXC0_HI)) |
                            (DATA_ADDR >= wwt_pkg::EXC1_LO);
    wire        ev_fetch  = MEM_CHECK & in_run & FETCH_VALID &
                            ~in_area(FETCH_ADDR, memsel_ff);
    wire        ev_data   = MEM_CHECK & in_run & DATA_VALID &
                            ~in_area(DATA_ADDR, memsel_ff) & ~data_exc;
    wire [wwt_pkg::ST_W-1:0] ev = {ev_data, ev_fetch, ev_closed, ev_key,
                                   ev_bitop, ev_ovf, ev_intv};
    wire        fault     = |ev[wwt_pkg::ST_W-1:1];
    wire        hold_end  = hold_ff == 4'h0;

    // ============================================================
    // controller next state
    always_comb begin
        nxt_state = state_ff;
        nxt_hold  = hold_ff;
        case (state_ff)
            wwt_pkg::WWT_RUN: begin
                // any fault starts the internal reset pulse
                if (fault) begin
                    nxt_state = wwt_pkg::WWT_HOLD;
                    nxt_hold  = wwt_pkg::RST_HOLD_CYC - 4'h1;
                end
            end
            wwt_pkg::WWT_HOLD: begin
                // count the pulse down, then resume from a fresh period
                if (hold_end) begin
                    nxt_state = wwt_pkg::WWT_RUN;
                end else begin
                    nxt_hold = hold_ff - 4'h1;
                end
            end
            default: begin
                nxt_state = wwt_pkg::WWT_RUN;
                nxt_hold  = 4'h0;
            end
        endcase
    end

    // counter and divider next values
    // hold, refresh and config writes all start a fresh period
    always_comb begin
        nxt_cnt = cnt_ff;
        nxt_pre = pre_ff;
        if (~in_run | fault | refresh | cfg_wr) begin
            nxt_cnt = '0;
            nxt_pre = 16'h0000;
        end else if (running) begin
            nxt_pre = tick ? 16'h0000 : pre_ff + 16'h0001;
            if (tick) begin
                nxt_cnt = cnt_ff + 17'h00001;
            end
        end
    end

    // sticky status: an event beats a read clear in the same cycle
    // only bits already returned on the read data are cleared, so an
    // event landing between data capture and completion is not lost
    for (genvar i = 0; i < wwt_pkg::ST_W; i++) begin : g_st
        assign nxt_st[i] = ev[i] | (st_ff[i] & ~(rd & sel_st & prdata_ff[i]));
    end

    // ============================================================
    // flops: controller and counter
    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            state_ff <= wwt_pkg::WWT_RUN;
            hold_ff  <= 4'h0;
            cnt_ff   <= '0;
            pre_ff   <= 16'h0000;
        end else begin
            state_ff <= nxt_state;
            hold_ff  <= nxt_hold;
            cnt_ff   <= nxt_cnt;
            pre_ff   <= nxt_pre;
        end
    end

    // flops: software registers
    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            cfg_ff    <= wwt_pkg::CONFIG_RST;
            memsel_ff <= wwt_pkg::MEMSEL_RST;
            mask_ff   <= '0;
            st_ff     <= '0;
        end else begin
            if (cfg_wr) cfg_ff <= PWDATA[7:0];
            if (wr & sel_mem) memsel_ff <= PWDATA[13:0];
            if (wr & sel_mask) mask_ff <= PWDATA[wwt_pkg::ST_W-1:0];
            st_ff <= nxt_st;
        end
    end

    // flops: bus answer and outputs
    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            pready_ff  <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff  <= 32'h00000000;
            irq_ff     <= 1'b0;
            rst_out_ff <= 1'b0;
        end else begin
            // ready pulses once per transfer, always after one wait state
            pready_ff  <= PSEL & PENABLE & ~pready_ff;
            pslverr_ff <= PSEL & PENABLE & ~pready_ff & ~mapped;
            prdata_ff  <= (PSEL & ~PWRITE) ? rd_mux : 32'h00000000;
            irq_ff     <= |(nxt_st & mask_ff);
            // taken from the next state so the pulse starts on the fault edge
            rst_out_ff <= nxt_state == wwt_pkg::WWT_HOLD;
        end
    end

    assign PRDATA    = prdata_ff;
    assign PREADY    = pready_ff;
    assign PSLVERR   = pslverr_ff;
    assign IRQ       = irq_ff;
    assign WDT_RESET = rst_out_ff;

    // ============================================================
    // assertions
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (!RST_N);

    sequence s_pulse;
        rst_out_ff [*8];
    endsequence
    sequence s_fresh;
        !rst_out_ff && cnt_ff == '0;
    endsequence
    // standby stop: nothing else may move the counter this cycle
    sequence s_frozen;
        STANDBY && !stby_run && in_run && !(fault || refresh || cfg_wr);
    endsequence

    refresh_clear_a: assert property (refresh |=> cnt_ff == '0 && !rst_out_ff)
        else $error("refresh did not clear counter");
    overflow_rst_a: assert property (ev_ovf |=> rst_out_ff && st_ff[wwt_pkg::ST_OVF])
        else $error("overflow gave no reset");
    bitop_rst_a: assert property (ev_bitop |=> state_ff == wwt_pkg::WWT_HOLD && rst_out_ff)
        else $error("bit op gave no reset");
    bad_key_a: assert property (ref_wr && !key_ok |=> rst_out_ff && st_ff[wwt_pkg::ST_KEY])
        else $error("wrong key gave no reset");
    closed_write_a: assert property (ref_wr && !win_open |=> rst_out_ff && st_ff[wwt_pkg::ST_CLOSED])
        else $error("closed window write missed");
    fetch_area_a: assert property (ev_fetch |=> rst_out_ff ##0 st_ff[wwt_pkg::ST_FETCH])
        else $error("bad fetch gave no reset");
    data_exempt_a: assert property (DATA_VALID && DATA_ADDR >= wwt_pkg::EXC1_LO |-> !ev_data)
        else $error("exempt data access flagged");
    release_clear_a: assert property ($rose(rst_out_ff) |-> s_pulse ##1 s_fresh)
        else $error("reset pulse or release wrong");
    count_bound_a: assert property (cnt_ff <= ovf_max)
        else $error("counter passed overflow");
    full_window_a: assert property (!stby_run |-> win_open)
        else $error("window not full without standby");
    run_gate_a: assert property (!cfg_ff[wwt_pkg::CFG_RUN] && in_run && !cfg_wr |=> $stable(cnt_ff))
        else $error("counter moved while disabled");
    interval_a: assert property (ev_intv |=> st_ff[wwt_pkg::ST_INTV] ##0 (IRQ == mask_ff[wwt_pkg::ST_INTV] || IRQ))
        else $error("interval event lost");
    data_area_a: assert property (ev_data |=> rst_out_ff && st_ff[wwt_pkg::ST_DATA])
        else $error("bad data access gave no reset");
    standby_stop_a: assert property (s_frozen |=> $stable(cnt_ff))
        else $error("counter moved in standby");
    // an unmasked status bit keeps the interrupt up until it is read
    irq_level_a: assert property (|(st_ff & mask_ff) && !(rd && sel_st) && !(wr && sel_mask) |=> IRQ)
        else $error("irq low with unmasked status");

endmodule : wwt_top

// ===== testbench.sv
`timescale 1ns/10ps
module testbench;
    // ====
    // stimulus and observed signals
    logic        REF_CLK, RST_N, PSEL, PENABLE, PWRITE, STANDBY;    // bench driven
    logic        FETCH_VALID, DATA_VALID;                          // access strobes
    logic        PREADY, PSLVERR, IRQ, WDT_RESET;                  // design driven
    logic [7:0]  PADDR;                                            // byte offset
    logic [31:0] PWDATA, PRDATA, r, x;                             // bus data
    logic        se;                                               // last slave error
    logic [15:0] FETCH_ADDR, DATA_ADDR, lfsr, a;                   // addresses
    int          err_count, cmp_count, cyc, irq_at, lat;           // bookkeeping
    localparam int DIV = 4;  // short slow period keeps the run brief
    wwt_top #(.LS_DIV(DIV), .MEM_CHECK(1'b1)) DUT (
        .REF_CLK(REF_CLK), .RST_N(RST_N), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
        .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
        .STANDBY(STANDBY), .FETCH_VALID(FETCH_VALID), .FETCH_ADDR(FETCH_ADDR),
        .DATA_VALID(DATA_VALID), .DATA_ADDR(DATA_ADDR), .IRQ(IRQ), .WDT_RESET(WDT_RESET));
    // ====
    // clock and hang guard
    initial begin
        REF_CLK = 1'b0;
        forever #20 REF_CLK = ~REF_CLK;
    end
    always @(posedge REF_CLK) begin
        cyc++;
        if (cyc == 60000) begin  // well above the six overflow runs, 44800 cycles in all
            err_count++;
            results();
        end
    end
    // ====
    // helpers
    function automatic logic [15:0] lfsr_next(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr_next
    function automatic logic [31:0] cfg(input logic sb, input logic [2:0] sel, input logic [1:0] sp);
        return {25'h0, sp, 1'b1, sel, sb};
    endfunction : cfg
    // rom 0..FFF, xram FA00..FAFF; data also free in the two high holes
    function automatic logic bad(input logic f, input logic [15:0] ad);
        if (ad < 16'h1000 || (ad >= 16'hFA00 && ad < 16'hFB00)) return 1'b0;
        return f || !((ad >= 16'hFB00 && ad <= 16'hFFCF) || ad >= 16'hFFE0);
    endfunction : bad
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_count++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    // one apb transfer; request held until pready is seen
    task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] d);
        @(posedge REF_CLK);
        PSEL <= 1'b1;
        PENABLE <= 1'b0;
        PWRITE <= w;
        PADDR <= ad;
        PWDATA <= d;
        @(posedge REF_CLK);
        PENABLE <= 1'b1;
        do @(posedge REF_CLK); while (PREADY !== 1'b1);
        r = PRDATA;
        se = PSLVERR;
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
    endtask : apb
    // wait for the reset pulse, noting when irq first rose
    task automatic pulse();
        int w;
        lat = 0;
        w = 0;
        irq_at = 0;
        while (WDT_RESET !== 1'b1 && lat < 40000) begin
            @(posedge REF_CLK);
            lat++;
            if (IRQ === 1'b1 && irq_at == 0) irq_at = lat;
        end
        while (WDT_RESET === 1'b1) begin
            @(posedge REF_CLK);
            w++;
        end
        check("reset pulse width", 32'(w), 32'h8);
    endtask : pulse
    // fault whose source is masked: status holds just that bit
    task automatic fault(input int b);
        pulse();
        check("masked irq", {31'h0, IRQ}, 32'h0);
        apb(1'b0, wwt_pkg::OFS_STATUS, 32'h0);
        check("fault status", r, 32'h1 << b);
    endtask : fault
    task automatic idle_ok();
        repeat (4) @(posedge REF_CLK);
        apb(1'b0, wwt_pkg::OFS_STATUS, 32'h0);
        check("no fault", r, 32'h0);
    endtask : idle_ok
    task automatic results();
        if (err_count == 0 && cmp_count > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : results
    // ====
    // main sequence
    initial begin
        {RST_N, PSEL, PENABLE, PWRITE, STANDBY, FETCH_VALID, DATA_VALID} = 7'h0;
        {PADDR, PWDATA, FETCH_ADDR, DATA_ADDR} = 72'h0;
        lfsr = 16'h000A;
        repeat (12) @(posedge REF_CLK);
        RST_N <= 1'b1;
        // reset values and a silent disabled counter
        apb(1'b0, wwt_pkg::OFS_CONFIG, 32'h0);
        check("config reset", r, 32'h0);
        repeat (300) @(posedge REF_CLK);
        apb(1'b0, wwt_pkg::OFS_COUNT, 32'h0);
        check("idle count", r, 32'h0);
        apb(1'b0, 8'h1C, 32'h0);
        check("unmapped error", {31'h0, se}, 32'h1);
        // overflow time for each short select, with interval warning
        apb(1'b1, wwt_pkg::OFS_MASK, 32'h1 << wwt_pkg::ST_INTV);
        for (int s = 0; s < 6; s++) begin
            apb(1'b1, wwt_pkg::OFS_CONFIG, cfg(1'b1, s[2:0], 2'h0));
            x = (32'h1 << wwt_pkg::OVF_EXP[s]) * DIV;
            pulse();
            check("overflow time", 32'(lat >= x - 2 && lat <= x + DIV + 3), 32'h1);
            check("interval time", 32'(irq_at >= x * 3 / 4 - 2 && irq_at <= x * 3 / 4 + DIV + 3), 32'h1);
            apb(1'b0, wwt_pkg::OFS_STATUS, 32'h0);
            check("overflow status", r, 32'h3);
            @(posedge REF_CLK);
            check("irq cleared", {31'h0, IRQ}, 32'h0);
        end
        // key in open window restarts from zero
        apb(1'b1, wwt_pkg::OFS_CONFIG, cfg(1'b1, 3'h0, 2'h0));
        repeat (150) @(posedge REF_CLK);
        apb(1'b0, wwt_pkg::OFS_COUNT, 32'h0);
        check("running count", 32'(r > 30 && r < 45), 32'h1);
        apb(1'b1, wwt_pkg::OFS_REFRESH, 32'hAC);
        apb(1'b0, wwt_pkg::OFS_COUNT, 32'h0);
        check("restarted count", 32'(r < 2), 32'h1);
        repeat (150) @(posedge REF_CLK);
        idle_ok();
        // window forced fully open without standby run
        apb(1'b1, wwt_pkg::OFS_CONFIG, cfg(1'b0, 3'h0, wwt_pkg::SPAN_50));
        apb(1'b1, wwt_pkg::OFS_REFRESH, 32'hAC);
        idle_ok();
        // closed part is the first half or first quarter of the period
        for (int k = 0; k < 2; k++) begin
            x = k ? 16 : 32;
            apb(1'b1, wwt_pkg::OFS_CONFIG, cfg(1'b1, 3'h0, k ? wwt_pkg::SPAN_75 : wwt_pkg::SPAN_50));
            repeat (x * DIV - 12) @(posedge REF_CLK);
            apb(1'b1, wwt_pkg::OFS_REFRESH, 32'hAC);
            fault(wwt_pkg::ST_CLOSED);
            apb(1'b1, wwt_pkg::OFS_CONFIG, cfg(1'b1, 3'h0, k ? wwt_pkg::SPAN_75 : wwt_pkg::SPAN_50));
            repeat (x * DIV + 8) @(posedge REF_CLK);
            apb(1'b1, wwt_pkg::OFS_REFRESH, 32'hAC);
            idle_ok();
        end
        // wrong key in closed window flags both causes
        apb(1'b1, wwt_pkg::OFS_REFRESH, 32'h0);
        pulse();
        apb(1'b0, wwt_pkg::OFS_STATUS, 32'h0);
        check("closed wrong key", r, 32'h18);
        // single-bit access even with the key value
        apb(1'b1, wwt_pkg::OFS_CONFIG, cfg(1'b1, 3'h0, 2'h0));
        apb(1'b1, wwt_pkg::OFS_BITOP, 32'hAC);
        fault(wwt_pkg::ST_BITOP);
        // random wrong keys, unmasked so irq follows status
        apb(1'b1, wwt_pkg::OFS_MASK, 32'h1 << wwt_pkg::ST_KEY);
        for (int i = 0; i < 6; i++) begin
            lfsr = lfsr_next(lfsr);
            // the longer selects too, window fully open
            apb(1'b1, wwt_pkg::OFS_CONFIG, cfg(1'b1, 3'(i + 2), 2'h0));
            apb(1'b1, wwt_pkg::OFS_REFRESH, {24'h0, lfsr[7:0] == 8'hAC ? 8'hAD : lfsr[7:0]});
            pulse();
            check("key irq", {31'h0, IRQ}, 32'h1);
            apb(1'b0, wwt_pkg::OFS_STATUS, 32'h0);
            check("key status", r, 32'h8);
        end
        // standby without standby run freezes the counter
        STANDBY <= 1'b1;
        apb(1'b1, wwt_pkg::OFS_CONFIG, cfg(1'b0, 3'h0, 2'h0));
        repeat (300) @(posedge REF_CLK);
        apb(1'b0, wwt_pkg::OFS_COUNT, 32'h0);
        check("standby count", r, 32'h0);
        STANDBY <= 1'b0;
        // reset in mid-run: counter and settings back to reset values
        repeat (100) @(posedge REF_CLK);
        RST_N <= 1'b0;
        repeat (2) @(posedge REF_CLK);
        RST_N <= 1'b1;
        apb(1'b0, wwt_pkg::OFS_COUNT, 32'h0);
        check("count after reset", r, 32'h0);
        apb(1'b0, wwt_pkg::OFS_CONFIG, 32'h0);
        check("config after reset", r, 32'h0);
        // area checks: corners first, then random addresses
        apb(1'b1, wwt_pkg::OFS_CONFIG, cfg(1'b1, 3'h3, 2'h0));
        apb(1'b1, wwt_pkg::OFS_MEMSEL, 32'h0104);
        for (int i = 0; i < 14; i++) begin
            lfsr = lfsr_next(lfsr);
            case (i)
                0: a = 16'h0FFF;
                1: a = 16'h1000;
                2: a = 16'hFA00;
                3: a = 16'hF9FF;
                4: a = 16'hFFD0;
                5: a = 16'hFFE0;
                6: a = 16'hFB00;
                default: a = lfsr;
            endcase
            for (int f = 0; f < 2; f++) begin
                @(posedge REF_CLK);
                FETCH_VALID <= f[0];
                DATA_VALID <= !f[0];
                FETCH_ADDR <= a;
                DATA_ADDR <= a;
                @(posedge REF_CLK);
                FETCH_VALID <= 1'b0;
                DATA_VALID <= 1'b0;
                if (bad(f[0], a)) fault(f ? wwt_pkg::ST_FETCH : wwt_pkg::ST_DATA);
                else idle_ok();
            end
        end
        results();
    end
endmodule : testbench
